/* File: verilog/sggs_gain_switcher.sv */
// Servo gain group switcher with gradual blend between two gain groups
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// RULE1: Select function 11: closed input picks second group, open picks first.
// RULE2: Select function 12: open input picks second group, closed picks first.
// RULE3: An assigned select input overrides the automatic switching method completely.
// RULE4: Method 0, the reset default, keeps the first group permanently.
// RULE5: Method 1: second group while absolute position error reaches threshold.
// RULE6: Method 2: second group while absolute speed reaches speed threshold.
// RULE7: Method 3: second group while absolute torque reaches torque threshold.
// RULE8: Method 4: second group while positioning is not complete.
// RULE9: Moving to second group blends gradually over advance delay, default 10 ms.
// RULE10: Returning to first group blends gradually over return delay, default 10 ms.
// RULE11: Each group holds seven coefficients; torque filter defaults to 1099.
// RULE12: Both groups reset alike: position gain 52, velocity gain 183.
// RULE13: Thresholds reset to 0 counts, 0 speed and 10 torque.
// RULE14: Blend each coefficient linearly, advancing once per millisecond tick.
module sggs_gain_switcher
  import sggs_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire logic gainSelClosed,
  input wire logic signed [31:0] posError,
  input wire logic signed [15:0] motorSpeed,
  input wire logic signed [15:0] motorTorque,
  input wire logic posComplete,
  output logic secondActive,
  output logic [15:0] posLoopGain,
  output logic [15:0] derivTime,
  output logic [15:0] derivFilter,
  output logic [15:0] velCmdGain,
  output logic [15:0] velLoopGain,
  output logic [15:0] integTime,
  output logic [15:0] torqFilterFreq
);

  function automatic logic [31:0] absOf(input logic signed [31:0] v);
    absOf = v[31] ? 32'(-v) : 32'(v);
  endfunction : absOf

  // A zero delay means switch fully at the next tick
  function automatic logic [16:0] stepOf(input logic [15:0] dly);
    stepOf = (dly == 16'h0000) ? ALPHA_FULL : 17'(ALPHA_FULL / {1'b0, dly});
  endfunction : stepOf

  // Configuration registers
  sggs_method_t method_r, method_nxt;
  logic [3:0] selFunc_r, selFunc_nxt;
  logic [31:0] posErrThr_r, posErrThr_nxt;
  logic [15:0] speedThr_r, speedThr_nxt;
  logic [15:0] torqThr_r, torqThr_nxt;
  logic [15:0] retDelay_r, retDelay_nxt;
  logic [15:0] advDelay_r, advDelay_nxt;
  logic [15:0] gain1_r [NCOEF];
  logic [15:0] gain1_nxt [NCOEF];
  logic [15:0] gain2_r [NCOEF];
  logic [15:0] gain2_nxt [NCOEF];
  logic [31:0] regRdData_r, regRdData_nxt;

  always_comb begin
    method_nxt = method_r;
    selFunc_nxt = selFunc_r;
    posErrThr_nxt = posErrThr_r;
    speedThr_nxt = speedThr_r;
    torqThr_nxt = torqThr_r;
    retDelay_nxt = retDelay_r;
    advDelay_nxt = advDelay_r;
    gain1_nxt = gain1_r;
    gain2_nxt = gain2_r;
    if (regWr) begin
      unique case (regAddr)
        ADDR_METHOD: begin
          // Codes above 4 are not methods; the write is dropped
          if (regWrData[2:0] <= 3'h4 && regWrData[31:3] == 29'h0) begin
            method_nxt = sggs_method_t'(regWrData[2:0]);
          end
        end
        ADDR_SELFUNC: selFunc_nxt = regWrData[3:0];
        ADDR_POSERR_THR: posErrThr_nxt = regWrData;
        ADDR_SPEED_THR: speedThr_nxt = regWrData[15:0];
        ADDR_TORQ_THR: torqThr_nxt = regWrData[15:0];
        ADDR_RET_DELAY: retDelay_nxt = regWrData[15:0];
        ADDR_ADV_DELAY: advDelay_nxt = regWrData[15:0];
        default: begin
          for (int i = 0; i < NCOEF; i++) begin
            if (regAddr == ADDR_GAIN1 + 8'(4 * i)) begin
              gain1_nxt[i] = regWrData[15:0];
            end
            if (regAddr == ADDR_GAIN2 + 8'(4 * i)) begin
              gain2_nxt[i] = regWrData[15:0];
            end
          end
        end
      endcase
    end
  end

  // Switching decision
  logic autoSecond;
  logic target_r, target_nxt;

  always_comb begin
    unique case (method_r)
      SGGS_FIXED: autoSecond = 1'b0; // see RULE4
      SGGS_POSERR: autoSecond = absOf(posError) >= posErrThr_r; // see RULE5
      SGGS_SPEED: autoSecond = absOf(32'(motorSpeed)) >= {16'h0, speedThr_r}; // see RULE6
      SGGS_TORQUE: autoSecond = absOf(32'(motorTorque)) >= {16'h0, torqThr_r}; // see RULE7
      SGGS_INPOS: autoSecond = !posComplete; // see RULE8
      default: autoSecond = 1'b0;
    endcase
    if (selFunc_r == SEL_CLOSED) begin
      target_nxt = gainSelClosed; // see RULE1 see RULE3
    end else if (selFunc_r == SEL_OPEN) begin
      target_nxt = !gainSelClosed; // see RULE2 see RULE3
    end else begin
      target_nxt = autoSecond;
    end
  end

  // Millisecond tick and blend factor, alpha 0 is pure first group
  logic [31:0] tickCnt_r, tickCnt_nxt;
  logic [16:0] alpha_r, alpha_nxt;
  logic tick;
  logic [16:0] stepUp;
  logic [16:0] stepDown;

  always_comb begin
    tick = (tickCnt_r == 32'(TICK_LEN - 1));
    tickCnt_nxt = tick ? 32'h0 : tickCnt_r + 32'h1;
    stepUp = stepOf(advDelay_r);
    stepDown = stepOf(retDelay_r);
    alpha_nxt = alpha_r;
    if (tick) begin
      if (target_r) begin
        // see RULE9 see RULE14
        alpha_nxt = (ALPHA_FULL - alpha_r <= stepUp) ? ALPHA_FULL : alpha_r + stepUp;
      end else begin
        // see RULE10 see RULE14
        alpha_nxt = (alpha_r <= stepDown) ? 17'h0 : alpha_r - stepDown;
      end
    end
  end

  // Blended coefficients, registered
  logic [15:0] gainOut_r [NCOEF];
  logic [15:0] gainOut_nxt [NCOEF];

  genvar g;
  generate
    for (g = 0; g < NCOEF; g++) begin : g_blend
      logic signed [17:0] diff;
      logic signed [35:0] prod;
      always_comb begin
        diff = 18'($signed({2'b00, gain2_r[g]}) - $signed({2'b00, gain1_r[g]}));
        prod = 36'(diff * $signed({1'b0, alpha_r}));
        gainOut_nxt[g] = 16'(gain1_r[g] + 16'(prod >>> 16)); // see RULE14
      end
    end
  endgenerate

  always_comb begin
    regRdData_nxt = 32'h0;
    if (regRd) begin
      unique case (regAddr)
        ADDR_METHOD: regRdData_nxt = {29'h0, method_r};
        ADDR_SELFUNC: regRdData_nxt = {28'h0, selFunc_r};
        ADDR_POSERR_THR: regRdData_nxt = posErrThr_r;
        ADDR_SPEED_THR: regRdData_nxt = {16'h0, speedThr_r};
        ADDR_TORQ_THR: regRdData_nxt = {16'h0, torqThr_r};
        ADDR_RET_DELAY: regRdData_nxt = {16'h0, retDelay_r};
        ADDR_ADV_DELAY: regRdData_nxt = {16'h0, advDelay_r};
        ADDR_STATUS: regRdData_nxt = {target_r, 14'h0, alpha_r};
        default: begin
          for (int i = 0; i < NCOEF; i++) begin
            if (regAddr == ADDR_GAIN1 + 8'(4 * i)) begin
              regRdData_nxt = {16'h0, gain1_r[i]};
            end
            if (regAddr == ADDR_GAIN2 + 8'(4 * i)) begin
              regRdData_nxt = {16'h0, gain2_r[i]};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      method_r <= SGGS_FIXED; // see RULE4
      selFunc_r <= SEL_NONE;
      posErrThr_r <= POSERR_THR_RST; // see RULE13
      speedThr_r <= SPEED_THR_RST;
      torqThr_r <= TORQ_THR_RST;
      retDelay_r <= RET_DELAY_RST;
      advDelay_r <= ADV_DELAY_RST;
      gain1_r <= GAIN_RST; // see RULE11 see RULE12
      gain2_r <= GAIN_RST;
      gainOut_r <= GAIN_RST;
      target_r <= 1'b0;
      tickCnt_r <= 32'h0;
      alpha_r <= 17'h0;
      regRdData_r <= 32'h0;
    end else begin
      method_r <= method_nxt;
      selFunc_r <= selFunc_nxt;
      posErrThr_r <= posErrThr_nxt;
      speedThr_r <= speedThr_nxt;
      torqThr_r <= torqThr_nxt;
      retDelay_r <= retDelay_nxt;
      advDelay_r <= advDelay_nxt;
      gain1_r <= gain1_nxt;
      gain2_r <= gain2_nxt;
      gainOut_r <= gainOut_nxt;
      target_r <= target_nxt;
      tickCnt_r <= tickCnt_nxt;
      alpha_r <= alpha_nxt;
      regRdData_r <= regRdData_nxt;
    end
  end

  assign regRdData = regRdData_r;
  assign secondActive = target_r;
  assign posLoopGain = gainOut_r[0];
  assign derivTime = gainOut_r[1];
  assign derivFilter = gainOut_r[2];
  assign velCmdGain = gainOut_r[3];
  assign velLoopGain = gainOut_r[4];
  assign integTime = gainOut_r[5];
  assign torqFilterFreq = gainOut_r[6];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_sel_closed_pick: assert property ( // see RULE1
    selFunc_r == SEL_CLOSED && $stable(selFunc_r) |=> target_r == $past(gainSelClosed))
    else $error("closed-active select did not follow the input");
  chk_sel_open_pick: assert property ( // see RULE2
    selFunc_r == SEL_OPEN && $stable(selFunc_r) |=> target_r == !$past(gainSelClosed))
    else $error("open-active select did not follow the input");
  chk_sel_overrides_auto: assert property ( // see RULE3
    selFunc_r == SEL_CLOSED && !gainSelClosed && autoSecond && !regWr
    |=> !target_r)
    else $error("automatic method overrode the select input");
  chk_open_overrides_auto: assert property ( // see RULE3
    selFunc_r == SEL_OPEN && gainSelClosed && autoSecond && !regWr
    |=> !target_r)
    else $error("automatic method overrode the open-active select input");
  chk_fixed_first: assert property ( // see RULE4
    selFunc_r == SEL_NONE && method_r == SGGS_FIXED && !regWr |=> !target_r ##1 !target_r[*1])
    else $error("method 0 selected the second group");
  chk_poserr_switch: assert property ( // see RULE5
    selFunc_r == SEL_NONE && method_r == SGGS_POSERR && !regWr
    |=> target_r == ($past(absOf(posError)) >= $past(posErrThr_r)))
    else $error("position error switching wrong");
  chk_inpos_switch: assert property ( // see RULE8
    selFunc_r == SEL_NONE && method_r == SGGS_INPOS && !regWr
    |=> target_r == !$past(posComplete))
    else $error("positioning complete switching wrong");
  chk_advance_ramp: assert property ( // see RULE9
    target_r && tick && alpha_r != ALPHA_FULL && advDelay_r != 16'h0
    |=> alpha_r > $past(alpha_r) && alpha_r <= ALPHA_FULL)
    else $error("advance blend did not step toward second group");
  chk_return_ramp: assert property ( // see RULE10
    !target_r && tick && alpha_r != 17'h0 |=> alpha_r < $past(alpha_r))
    else $error("return blend did not step toward first group");
  chk_blend_hold: assert property ( // see RULE14
    !tick |=> alpha_r == $past(alpha_r))
    else $error("blend moved between ticks");
  chk_pure_first: assert property ( // see RULE14
    alpha_r == 17'h0 |=> velLoopGain == $past(gain1_r[4]))
    else $error("output differs from first group at zero blend");
  chk_pure_second: assert property ( // see RULE9
    alpha_r == ALPHA_FULL |=> velLoopGain == $past(gain2_r[4]))
    else $error("output differs from second group at full blend");
  chk_return_floor: assert property ( // see RULE10
    !target_r && alpha_r == 17'h0 |=> alpha_r == 17'h0)
    else $error("blend left the first group with no second-group request");

  // Both signed bounds are checked so the abs helper is not trusted twice
  chk_speed_switch: assert property ( // see RULE6
    selFunc_r == SEL_NONE && method_r == SGGS_SPEED && !regWr
    |=> target_r == ($past(motorSpeed) >= $signed({1'b0, $past(speedThr_r)})
    || $past(motorSpeed) <= -$signed({1'b0, $past(speedThr_r)})))
    else $error("speed switching wrong");
  chk_torque_switch: assert property ( // see RULE7
    selFunc_r == SEL_NONE && method_r == SGGS_TORQUE && !regWr
    |=> target_r == ($past(motorTorque) >= $signed({1'b0, $past(torqThr_r)})
    || $past(motorTorque) <= -$signed({1'b0, $past(torqThr_r)})))
    else $error("torque switching wrong");

  // Stale read data would let a later poll see an old word
  chk_rd_idle: assert property (
    !regRd |=> regRdData == 32'h0)
    else $error("read data stood longer than one cycle");

endmodule : sggs_gain_switcher

`default_nettype wire

/* File: verilog/sggs_pkg.sv */
// Constants shared by the servo gain group switcher
package sggs_pkg;
  localparam int NCOEF = 7;
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [16:0] ALPHA_FULL = 17'h10000;
  // Register byte addresses
  localparam logic [7:0] ADDR_METHOD = 8'h00;
  localparam logic [7:0] ADDR_SELFUNC = 8'h04;
  localparam logic [7:0] ADDR_POSERR_THR = 8'h08;
  localparam logic [7:0] ADDR_SPEED_THR = 8'h0c;
  localparam logic [7:0] ADDR_TORQ_THR = 8'h10;
  localparam logic [7:0] ADDR_RET_DELAY = 8'h14;
  localparam logic [7:0] ADDR_ADV_DELAY = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_GAIN1 = 8'h20;
  localparam logic [7:0] ADDR_GAIN2 = 8'h40;
  localparam int STATUS_TARGET_BIT = 31;
  // Select input function codes
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_CLOSED = 4'hb;
  localparam logic [3:0] SEL_OPEN = 4'hc;
  // Reset values
  localparam logic [31:0] POSERR_THR_RST = 32'h0000_0000;
  localparam logic [15:0] SPEED_THR_RST = 16'h0000;
  localparam logic [15:0] TORQ_THR_RST = 16'h000a;
  localparam logic [15:0] RET_DELAY_RST = 16'h000a;
  localparam logic [15:0] ADV_DELAY_RST = 16'h000a;
  // Coefficient order: pos gain, deriv time, deriv filter, vel cmd gain,
  // vel loop gain, integral time, torque filter freq
  localparam logic [15:0] GAIN_RST [NCOEF] = '{16'h0034, 16'h0000, 16'h4e20, 16'h2710,
                                               16'h00b7, 16'h00bd, 16'h044b};
  typedef enum logic [2:0] {
    SGGS_FIXED = 3'b000,
    SGGS_POSERR = 3'b001,
    SGGS_SPEED = 3'b010,
    SGGS_TORQUE = 3'b011,
    SGGS_INPOS = 3'b100
  } sggs_method_t;
endpackage : sggs_pkg

/* File: tb/sggs_sel_switch.sv */
// Model of the external contact that drives the gain select input
`timescale 1ns/100ps
`default_nettype none
module sggs_sel_switch (
  input wire logic sys_clk,
  input wire logic wantClosed,
  input wire logic [3:0] lagCycles,
  output logic gainSelClosed
);
  logic [3:0] lagCnt_r;
  initial begin
    gainSelClosed = 1'b0;
    lagCnt_r = 4'h0;
  end
  // A slow contact only settles after lagCycles edges of disagreement
  always @(posedge sys_clk) begin
    if (wantClosed == gainSelClosed) begin
      lagCnt_r <= 4'h0;
    end else if (lagCnt_r >= lagCycles) begin
      gainSelClosed <= wantClosed;
      lagCnt_r <= 4'h0;
    end else begin
      lagCnt_r <= lagCnt_r + 4'h1;
    end
  end
endmodule : sggs_sel_switch
`default_nettype wire

/* File: tb/sggs_gain_switcher_tb.sv */
// Self-checking bench for the servo gain group switcher
`timescale 1ns/100ps
`default_nettype none
module sggs_gain_switcher_tb;
  import sggs_pkg::*;
  localparam int TL = 10;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic wantClosed = 1'b0;
  logic [3:0] lagCycles = 4'h0;
  logic signed [31:0] posError = 32'h0;
  logic signed [15:0] motorSpeed = 16'h0;
  logic signed [15:0] motorTorque = 16'h0;
  logic posComplete = 1'b1;
  logic [31:0] regRdData;
  logic gainSelClosed;
  logic secondActive;
  logic [15:0] posLoopGain, derivTime, derivFilter, velCmdGain;
  logic [15:0] velLoopGain, integTime, torqFilterFreq;
  logic [31:0] d;
  logic [15:0] q [$];
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int mth = 0;
  int sf = 0;
  int val;
  int thr [3] = '{0, 0, 10};
  int g1 [7];
  int g2 [7];
  wire logic [111:0] coAll = {posLoopGain, derivTime, derivFilter, velCmdGain, velLoopGain,
                              integTime, torqFilterFreq};

  sggs_gain_switcher #(.TICK_LEN(TL)) uut (
    .sys_clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .gainSelClosed,
    .posError, .motorSpeed, .motorTorque, .posComplete, .secondActive, .posLoopGain,
    .derivTime, .derivFilter, .velCmdGain, .velLoopGain, .integTime, .torqFilterFreq
  );
  sggs_sel_switch partner (.sys_clk, .wantClosed, .lagCycles, .gainSelClosed);

  always #20 sys_clk = ~sys_clk;
  // Whole run needs about 500 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 5000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("fail_count %0d check_count %0d", fail_count, check_count);
    if (fail_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [111:0] got, input logic [111:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    // Model keeps only what the block accepts
    case (a)
      ADDR_METHOD: if (v <= 4) mth = v;
      ADDR_SELFUNC: sf = v[3:0];
      ADDR_POSERR_THR: thr[0] = v;
      ADDR_SPEED_THR: thr[1] = v[15:0];
      ADDR_TORQ_THR: thr[2] = v[15:0];
      default: ;
    endcase
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 r = regRdData;
  endtask : rd

  task automatic drive(input int pe, input int sp, input int tq, input logic pc);
    @(posedge sys_clk);
    posError <= pe;
    motorSpeed <= 16'(sp);
    motorTorque <= 16'(tq);
    posComplete <= pc;
  endtask : drive

  function automatic logic mtarget();
    if (sf == 11) return gainSelClosed;
    if (sf == 12) return !gainSelClosed;
    case (mth)
      1: return (posError < 0 ? -posError : posError) >= thr[0];
      2: return (motorSpeed < 0 ? -motorSpeed : motorSpeed) >= thr[1];
      3: return (motorTorque < 0 ? -motorTorque : motorTorque) >= thr[2];
      4: return !posComplete;
      default: return 1'b0;
    endcase
  endfunction : mtarget

  function automatic logic [111:0] pack(input int g [7]);
    logic [111:0] p;
    for (int i = 0; i < 7; i++) p[16*(6-i) +: 16] = 16'(g[i]);
    return p;
  endfunction : pack

  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1 chk(secondActive, mtarget());
  endtask : settle

  initial begin
    d = $urandom(32'h5449580a);
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      g1[i] = GAIN_RST[i];
      g2[i] = (i == 0) ? 32'h4000 : $urandom_range(0, 32'hffff);
      rd(8'(4 * i), d);
      chk(d, (i > 3) ? 32'ha : 32'h0);
      rd(ADDR_GAIN1 + 8'(4 * i), d);
      chk(d, 32'(g1[i]));
      rd(ADDR_GAIN2 + 8'(4 * i), d);
      chk(d, 32'(g1[i]));
      wr(ADDR_GAIN2 + 8'(4 * i), 32'(g2[i]));
    end
    #1 chk(coAll, pack(g1));
    wr(8'h60, 32'h1234);
    rd(8'h60, d);
    chk(d, 32'h0);
    wr(ADDR_METHOD, 32'h7);
    drive(1000, 1000, 1000, 1'b0);
    repeat (3 * TL) @(posedge sys_clk);
    settle();
    chk(coAll, pack(g1));
    wr(ADDR_METHOD, 32'h4);
    repeat (5 * TL) @(posedge sys_clk);
    #1 chk(coAll === pack(g2), 1'b0);
    repeat (8 * TL) @(posedge sys_clk);
    #1 chk(coAll, pack(g2));
    rd(ADDR_STATUS, d);
    chk(d, 32'h8001_0000);
    settle();
    wr(ADDR_RET_DELAY, 32'h4);
    q = {posLoopGain};
    drive(0, 0, 0, 1'b1);
    repeat (6 * TL) begin
      @(posedge sys_clk);
      #1 if (posLoopGain !== q[$]) q.push_back(posLoopGain);
    end
    settle();
    for (int k = 4; k >= 0; k--) begin
      val = g1[0] + int'((longint'(g2[0] - g1[0]) * (k * 32'h4000)) >>> 16);
      chk(q.size() > 0 ? q.pop_front() : 16'hxxxx, 16'(val));
    end
    chk(q.size(), 0);
    rd(ADDR_STATUS, d);
    chk(d, 32'h0);
    for (int m = 1; m < 4; m++) begin
      thr[m-1] = $urandom_range(1, 1000);
      wr(ADDR_POSERR_THR + 8'(4 * (m - 1)), 32'(thr[m-1]));
      wr(ADDR_METHOD, 32'(m));
      for (int j = 0; j < 4; j++) begin
        val = ((j % 2) ? -1 : 1) * (thr[m-1] - j / 2);
        drive(val, val, val, 1'b1);
        settle();
      end
    end
    drive(2000, 2000, 2000, 1'b1);
    for (int c = 11; c < 13; c++) begin
      wr(ADDR_SELFUNC, 32'(c));
      for (int l = 0; l < 2; l++) begin
        lagCycles <= 4'($urandom_range(0, 15));
        wantClosed <= l[0];
        for (int w = 0; w < 20 && gainSelClosed !== l[0]; w++) @(posedge sys_clk);
        settle();
      end
    end
    wr(ADDR_SELFUNC, 32'h0);
    settle();
    final_report();
  end
endmodule : sggs_gain_switcher_tb
`default_nettype wire
